/* rtl/eep_defs.svh */
// Constants of the three-wire serial EEPROM block.
`ifndef EEP_DEFS_SVH
`define EEP_DEFS_SVH
`define EEP_CLK_NS 10
`define EEP_T_WP_MAX_NS 10000000
`define EEP_WORD_W 16
`define EEP_BYTE_W 8
`define EEP_ADDR_W 9
`define EEP_CNT_W 5
`define EEP_TMR_W 20
`define EEP_OP_W 2
`define EEP_OP_READ 2'h2
`define EEP_OP_WRITE 2'h1
`define EEP_OP_ERASE 2'h3
`define EEP_OP_EXT 2'h0
`define EEP_EXT_ENABLE 2'h3
`define EEP_EXT_ERASE_ALL 2'h2
`define EEP_EXT_WRITE_ALL 2'h1
`define EEP_EXT_DISABLE 2'h0
`define EEP_ERASED 16'hFFFF
`define EEP_BUF_DEPTH 2'h2
`define EEP_BE_LOW 2'h1
`define EEP_BE_HIGH 2'h2
`define EEP_BE_BOTH 2'h3
`endif

/* rtl/eep_pkg.sv */
// Types of the three-wire serial EEPROM block.
`include "eep_defs.svh"
package eep_pkg;
   typedef enum logic [2:0] {ST_IDLE, ST_CMD, ST_DATA, ST_READ, ST_HOLD}
      eep_state_t;
   typedef struct packed {
      logic cs_s1;
      logic cs_s2;
      logic cs_prev;
      logic sk_s1;
      logic sk_s2;
      logic sk_prev;
      logic di_s1;
      logic di_s2;
      logic org_s1;
      logic org_s2;
      eep_state_t st;
      logic [`EEP_CNT_W-1:0] cnt;
      logic [`EEP_WORD_W-1:0] sh;
      logic [`EEP_WORD_W-1:0] dat;
      logic [`EEP_WORD_W-1:0] out_sr;
      logic [`EEP_CNT_W-1:0] out_cnt;
      logic [`EEP_ADDR_W-1:0] rd_addr;
      logic [`EEP_WORD_W-1:0] buf0;
      logic [`EEP_WORD_W-1:0] buf1;
      logic [1:0] bcnt;
      logic inflight;
      logic pf_lsb;
      logic program_enable_cmd;
      logic status;
      logic wr_flag;
      logic busy;
      logic wr_go;
      logic wr_all;
      logic [`EEP_ADDR_W-2:0] wr_addr;
      logic [1:0] wr_be;
      logic [`EEP_WORD_W-1:0] wr_data;
      logic [`EEP_TMR_W-1:0] timer;
      logic do_o;
      logic oe_o;
   } eep_core_t;
endpackage : eep_pkg

/* rtl/eep_mem.sv */
// Word array with byte-lane writes and a registered read port.
`timescale 1ns/100ps
`include "eep_defs.svh"
module eep_mem #(
   parameter int AW = 8
) (
   input wire logic clk,
   input wire logic we,
   input wire logic [1:0] be,
   input wire logic [AW-1:0] addr,
   input wire logic [`EEP_WORD_W-1:0] wdata,
   output logic [`EEP_WORD_W-1:0] rdata
);
   if (AW < 1 || AW > `EEP_ADDR_W - 1) begin : g_chk
      $error("eep_mem: unsupported address width");
   end

   // One lane per byte so the x8 organisation writes half a word.
   // Each lane owns its array, so no two processes write one variable.
   // Registered read keeps the data path timing independent of the array.
   for (genvar i = 0; i < 2; i++) begin : g_lane
      logic [`EEP_BYTE_W-1:0] lane [0:(1<<AW)-1];
      logic [`EEP_BYTE_W-1:0] rd_q;
      always_ff @(posedge clk) begin
         if (we && be[i]) begin
            lane[addr] <= wdata[i*`EEP_BYTE_W +: `EEP_BYTE_W];
         end
         rd_q <= lane[addr];
      end
      assign rdata[i*`EEP_BYTE_W +: `EEP_BYTE_W] = rd_q;
   end
endmodule : eep_mem

/* rtl/eep_top.sv */
// Three-wire serial EEPROM: link decoder, write engine and read streamer.
//
// Behaviour
// - The word width is 16 bits with the width strap high, 8 bits low.
// - The array holds 2048 or 4096 bits, and the address length follows.
// - The host raises chip select and talks over clock, data in and out.
// - A read command decodes its address and shifts the word out.
// - Writes are self-timed and overwrite without a prior erase.
// - Every self-timed write finishes within 10 ms of its start.
// - Programming starts only in the enabled state, else memory is kept.
// - After a write starts, raising chip select again shows ready/busy.
// - Reads continue through successive words within one access.
// - A command is a one start bit, two opcode bits and an address.
// - The enable command is opcode 00 with prefix 11 and arms programming.
// - Prefix 10 erases every word and prefix 01 writes data to every word.
`timescale 1ns/100ps
`include "eep_defs.svh"
module eep_top #(
   parameter int A16_W = 8,
   parameter int WRITE_CYCLES = `EEP_T_WP_MAX_NS / `EEP_CLK_NS
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic chip_select,
   input wire logic shift_clock,
   input wire logic serial_data_in,
   input wire logic word_width_select,
   output logic serial_data_out,
   output logic serial_data_out_oe
);
   eep_pkg::eep_core_t q;
   eep_pkg::eep_core_t d;
   logic mem_we;
   logic [1:0] mem_be;
   logic [A16_W-1:0] mem_addr;
   logic [`EEP_WORD_W-1:0] mem_wd;
   logic [`EEP_WORD_W-1:0] mem_rd;
   logic fill_valid;
   logic fill_ready;
   logic drain_valid;
   logic drain_ready;

   if (A16_W < 7 || A16_W > `EEP_ADDR_W - 1) begin : g_chk_a
      $error("eep_top: A16_W must be 7 or 8");
   end
   if (WRITE_CYCLES <= (1 << A16_W) ||
       WRITE_CYCLES >= (1 << `EEP_TMR_W)) begin : g_chk_t
      $error("eep_top: WRITE_CYCLES out of range");
   end

   eep_mem #(
      .AW(A16_W)
   ) u_mem (
      .clk(clk),
      .we(mem_we),
      .be(mem_be),
      .addr(mem_addr),
      .wdata(mem_wd),
      .rdata(mem_rd)
   );

   // Two-entry buffer handshakes between the prefetch and the serialiser.
   assign fill_valid = q.inflight;
   assign fill_ready = q.bcnt != `EEP_BUF_DEPTH;
   assign drain_valid = q.bcnt != 2'h0;

   // All state moves here; pins are synchronised before anything reads them.
   always_comb begin
      logic sk_rise;
      logic cs_rise;
      logic org16;
      logic [3:0] alen;
      logic [`EEP_CNT_W-1:0] dlen;
      logic [`EEP_WORD_W-1:0] sh_n;
      logic [`EEP_WORD_W-1:0] tmp;
      logic [`EEP_WORD_W-1:0] amask;
      logic [`EEP_WORD_W-1:0] word;
      logic [1:0] nb;
      logic st_req;
      logic st_all;
      logic [`EEP_WORD_W-1:0] st_data;
      logic [`EEP_ADDR_W-1:0] st_addr;
      logic issue;
      d = q;
      sk_rise = q.sk_s2 & ~q.sk_prev;
      cs_rise = q.cs_s2 & ~q.cs_prev;
      org16 = q.org_s2;
      alen = org16 ? 4'(A16_W) : 4'(A16_W + 1);
      dlen = org16 ? `EEP_CNT_W'(`EEP_WORD_W) : `EEP_CNT_W'(`EEP_BYTE_W);
      amask = `EEP_WORD_W'((16'h1 << alen) - 16'h1);
      sh_n = {q.sh[`EEP_WORD_W-2:0], q.di_s2};
      tmp = '0;
      word = '0;
      nb = 2'h0;
      st_req = 1'b0;
      st_all = 1'b0;
      st_data = `EEP_ERASED;
      st_addr = '0;
      drain_ready = 1'b0;
      mem_we = 1'b0;
      mem_be = q.wr_be;
      mem_wd = q.wr_data;
      d.cs_s1 = chip_select;
      d.cs_s2 = q.cs_s1;
      d.cs_prev = q.cs_s2;
      d.sk_s1 = shift_clock;
      d.sk_s2 = q.sk_s1;
      d.sk_prev = q.sk_s2;
      d.di_s1 = serial_data_in;
      d.di_s2 = q.di_s1;
      d.org_s1 = word_width_select;
      d.org_s2 = q.org_s1;

      // Command decoder, one step per rising shift clock edge.
      if (!q.cs_s2) begin
         d.st = eep_pkg::ST_IDLE;
         d.status = 1'b0;
         d.bcnt = 2'h0;
         d.inflight = 1'b0;
      end else begin
         if (cs_rise && (q.busy || q.wr_flag)) begin
            d.status = 1'b1;
         end
         if (sk_rise) begin
            case (q.st)
               eep_pkg::ST_IDLE: begin
                  // Start bits are ignored while a write cycle runs.
                  if (q.di_s2 && !q.busy) begin
                     d.st = eep_pkg::ST_CMD;
                     d.cnt = '0;
                     d.sh = '0;
                     d.status = 1'b0;
                     d.wr_flag = 1'b0;
                  end
               end
               eep_pkg::ST_CMD: begin
                  d.sh = sh_n;
                  d.cnt = q.cnt + `EEP_CNT_W'(1);
                  if (q.cnt == `EEP_CNT_W'(alen) + `EEP_CNT_W'(1)) begin
                     tmp = sh_n >> alen;
                     st_addr = `EEP_ADDR_W'(sh_n & amask);
                     d.st = eep_pkg::ST_HOLD;
                     case (tmp[1:0])
                        `EEP_OP_READ: begin
                           d.st = eep_pkg::ST_READ;
                           d.rd_addr = st_addr;
                           d.out_cnt = '0;
                           d.do_o = 1'b0;
                        end
                        `EEP_OP_WRITE: begin
                           d.wr_all = 1'b0; // A cut bulk frame must not leak.
                           d.st = eep_pkg::ST_DATA;
                           d.cnt = '0;
                           d.rd_addr = st_addr;
                        end
                        `EEP_OP_ERASE: begin
                           st_req = 1'b1;
                        end
                        default: begin
                           tmp = sh_n >> (alen - 4'h2);
                           case (tmp[1:0])
                              `EEP_EXT_ENABLE: d.program_enable_cmd = 1'b1;
                              `EEP_EXT_DISABLE: d.program_enable_cmd = 1'b0;
                              `EEP_EXT_ERASE_ALL: begin
                                 st_req = 1'b1;
                                 st_all = 1'b1;
                              end
                              default: begin
                                 d.st = eep_pkg::ST_DATA;
                                 d.cnt = '0;
                                 d.wr_all = 1'b1;
                              end
                           endcase
                        end
                     endcase
                  end
               end
               eep_pkg::ST_DATA: begin
                  d.dat = {q.dat[`EEP_WORD_W-2:0], q.di_s2};
                  d.cnt = q.cnt + `EEP_CNT_W'(1);
                  if (q.cnt == dlen - `EEP_CNT_W'(1)) begin
                     st_req = 1'b1;
                     st_all = q.wr_all;
                     st_addr = q.rd_addr;
                     st_data = org16 ? d.dat :
                        {d.dat[`EEP_BYTE_W-1:0], d.dat[`EEP_BYTE_W-1:0]};
                     d.st = eep_pkg::ST_HOLD;
                  end
               end
               eep_pkg::ST_READ: begin
                  // A new word is pulled only when the last bit has gone.
                  if (q.out_cnt == '0) begin
                     if (drain_valid) begin
                        drain_ready = 1'b1;
                        d.do_o = q.buf0[`EEP_WORD_W-1];
                        d.out_sr = q.buf0 << 1;
                        d.out_cnt = dlen - `EEP_CNT_W'(1);
                     end
                  end else begin
                     d.do_o = q.out_sr[`EEP_WORD_W-1];
                     d.out_sr = q.out_sr << 1;
                     d.out_cnt = q.out_cnt - `EEP_CNT_W'(1);
                  end
               end
               default: begin
               end
            endcase
         end
      end

      // Launch of a write cycle; refused outside the enabled state.
      if (st_req && q.program_enable_cmd && !q.busy) begin
         d.busy = 1'b1;
         d.wr_go = 1'b1;
         d.wr_flag = 1'b1;
         d.timer = '0;
         d.wr_data = st_data;
         d.wr_all = st_all;
         if (st_all) begin
            d.wr_addr = '0;
            d.wr_be = `EEP_BE_BOTH;
         end else if (org16) begin
            d.wr_addr = st_addr[`EEP_ADDR_W-2:0];
            d.wr_be = `EEP_BE_BOTH;
         end else begin
            d.wr_addr = st_addr[`EEP_ADDR_W-1:1];
            d.wr_be = st_addr[0] ? `EEP_BE_HIGH : `EEP_BE_LOW;
         end
      end else if (st_req) begin
         d.wr_all = 1'b0;
      end

      // Self-timed engine: walk the words, then wait out the cycle time.
      if (q.busy) begin
         mem_we = q.wr_go;
         if (q.wr_go && (!q.wr_all || &q.wr_addr[A16_W-1:0])) begin
            d.wr_go = 1'b0;
         end else if (q.wr_go) begin
            d.wr_addr = q.wr_addr + 1'b1;
         end
         d.timer = q.timer + 1'b1;
         if (q.timer == `EEP_TMR_W'(WRITE_CYCLES - 1)) begin
            d.busy = 1'b0;
            d.wr_all = 1'b0;
         end
      end

      // Prefetch up to two words ahead so a fast shift clock never starves.
      issue = q.st == eep_pkg::ST_READ && q.cs_s2 && !q.inflight &&
         fill_ready && !q.busy;
      mem_addr = q.busy ? q.wr_addr[A16_W-1:0] :
         (org16 ? q.rd_addr[A16_W-1:0] : q.rd_addr[A16_W:1]);
      if (issue) begin
         d.inflight = 1'b1;
         d.pf_lsb = q.rd_addr[0];
         d.rd_addr = `EEP_ADDR_W'((q.rd_addr + 1'b1) & amask);
      end else if (q.inflight) begin
         d.inflight = 1'b0;
      end
      if (org16) begin
         word = mem_rd;
      end else begin
         word = q.pf_lsb ? {mem_rd[`EEP_WORD_W-1:`EEP_BYTE_W], 8'h00} :
            {mem_rd[`EEP_BYTE_W-1:0], 8'h00};
      end
      if (q.cs_s2) begin
         nb = q.bcnt - 2'(drain_ready && drain_valid);
         if (drain_ready && drain_valid) begin
            d.buf0 = q.buf1;
         end
         if (fill_valid && fill_ready) begin
            if (nb == 2'h0) begin
               d.buf0 = word;
            end else begin
               d.buf1 = word;
            end
         end
         d.bcnt = nb + 2'(fill_valid && fill_ready);
      end

      // Output pin: status overrides data, and it floats with select low.
      if (d.status) begin
         d.do_o = ~q.busy;
      end
      d.oe_o = q.cs_s2 && (d.status || d.st == eep_pkg::ST_READ);
   end

   // Synchronous reset clears every state bit.
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign serial_data_out = q.do_o;
   assign serial_data_out_oe = q.oe_o;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);
   AST_FLOAT_WHEN_DESELECTED: assert property (
      !q.cs_s2 |=> !serial_data_out_oe)
      else $error("data out driven while deselected");
   AST_STATUS_BUSY_LOW: assert property (
      q.status && q.busy && q.cs_s2 |=> serial_data_out_oe && !serial_data_out)
      else $error("busy status not shown low");
   AST_TIMER_BOUND: assert property (
      q.busy |-> q.timer < `EEP_TMR_W'(WRITE_CYCLES))
      else $error("write cycle overran its time");
   AST_START_NEEDS_ENABLE: assert property (
      $rose(q.busy) |-> $past(q.program_enable_cmd))
      else $error("write started without enable");
   AST_BUSY_ENDS_ON_TIME: assert property (
      $fell(q.busy) |-> $past(q.timer) == `EEP_TMR_W'(WRITE_CYCLES - 1))
      else $error("write cycle ended at the wrong count");
   AST_WRITE_ONLY_BUSY: assert property (
      mem_we |-> q.busy && q.timer < `EEP_TMR_W'(1 << A16_W))
      else $error("array written outside a write cycle");
   AST_READ_DUMMY_ZERO: assert property (
      q.st != eep_pkg::ST_READ ##1 q.st == eep_pkg::ST_READ && q.cs_s2
      |=> serial_data_out_oe && !serial_data_out)
      else $error("read did not open with a low dummy bit");
   AST_BUFFER_NO_OVERFLOW: assert property (
      fill_valid && q.cs_s2 |-> fill_ready)
      else $error("prefetch pushed into a full buffer");
   AST_DATA_LENGTH: assert property (
      q.st == eep_pkg::ST_DATA |-> q.cnt < (q.org_s2 ?
         `EEP_CNT_W'(`EEP_WORD_W) : `EEP_CNT_W'(`EEP_BYTE_W)))
      else $error("data phase longer than the word");
   COV_READ: cover property (q.st == eep_pkg::ST_READ && drain_ready);
   COV_WRITE_DONE: cover property ($fell(q.busy));
   COV_STATUS: cover property (q.status && q.cs_s2 ##1 serial_data_out_oe);
   COV_BULK: cover property (q.busy && q.wr_all && mem_we);
endmodule : eep_top

/* dv/eep_host.sv */
// Host model that drives the three-wire link of the serial EEPROM block.
`timescale 1ns/100ps
module eep_host (
   input wire logic clk,
   output logic chip_select,
   output logic shift_clock,
   output logic serial_data_in,
   input wire logic serial_data_out
);
   // Half link period in system clocks; 8 gives 80 ns, larger is slower.
   int half = 8;

   // The link clock stands still low outside frames.
   initial begin
      chip_select = 1'b0;
      shift_clock = 1'b0;
      serial_data_in = 1'b0;
   end

   // Moves select with the link clock parked, so the synchronisers settle.
   task automatic sel(input logic v);
      repeat (half) @(negedge clk);
      chip_select = v;
      serial_data_in = 1'b0;
      repeat (half) @(negedge clk);
   endtask : sel

   // One link clock; data out is taken late in the high phase.
   task automatic pulse(input logic b, output logic q);
      serial_data_in = b;
      repeat (half) @(negedge clk);
      shift_clock = 1'b1;
      repeat (half) @(negedge clk);
      q = serial_data_out;
      shift_clock = 1'b0;
   endtask : pulse

   // Shifts the low n bits of v, most significant bit first.
   task automatic send(input int n, input logic [31:0] v);
      logic q;
      for (int i = n - 1; i >= 0; i--) begin
         pulse(v[i], q);
      end
   endtask : send

   // Collects n bits of data out, first bit ending up most significant.
   task automatic recv(input int n, output logic [31:0] v);
      logic q;
      v = '0;
      for (int i = 0; i < n; i++) begin
         pulse(1'b0, q);
         v = {v[30:0], q};
      end
   endtask : recv
endmodule : eep_host

/* dv/eep_top_tb.sv */
// Self-checking bench of the serial EEPROM block.
`timescale 1ns/100ps
`include "eep_defs.svh"
module eep_top_tb;
   localparam int WC = 600;
   logic clk;
   logic rst_b;
   logic chip_select;
   logic shift_clock;
   logic serial_data_in;
   logic word_width_select;
   logic serial_data_out;
   logic serial_data_out_oe;
   logic link_do;
   int miscompares = 0;
   int checks_done = 0;
   int aw = 8;
   int dw = 16;

   // System clock, 10 ns period.
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // A short write time keeps the run brief; the status checks scale by it.
   eep_top #(.WRITE_CYCLES(WC)) dut (
      .clk(clk),
      .rst_b(rst_b),
      .chip_select(chip_select),
      .shift_clock(shift_clock),
      .serial_data_in(serial_data_in),
      .word_width_select(word_width_select),
      .serial_data_out(serial_data_out),
      .serial_data_out_oe(serial_data_out_oe)
   );

   // The host sees the pin, not the register: a floating pin reads as
   // the inverse of the last bit, so a read with oe low cannot pass.
   assign link_do = serial_data_out_oe ? serial_data_out : ~serial_data_out;

   eep_host host (
      .clk(clk),
      .chip_select(chip_select),
      .shift_clock(shift_clock),
      .serial_data_in(serial_data_in),
      .serial_data_out(link_do)
   );

   task automatic chk(input string what, input logic [31:0] exp,
         input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic final_report;
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : final_report

   // The strap only moves between frames, never inside one.
   task automatic set_width(input logic wide);
      word_width_select = wide;
      aw = wide ? 8 : 9;
      dw = wide ? 16 : 8;
      repeat (4) @(negedge clk);
   endtask : set_width

   function automatic logic [8:0] ext(input logic [1:0] sub);
      return (aw == 8) ? {1'b0, sub, 6'h00} : {sub, 7'h00};
   endfunction : ext

   task automatic cmd(input logic [1:0] op, input logic [8:0] a);
      host.sel(1'b1);
      host.send(3, {29'h0, 1'b1, op});
      host.send(aw, {23'h0, a});
   endtask : cmd

   task automatic arm(input logic [1:0] sub);
      cmd(`EEP_OP_EXT, ext(sub));
      host.sel(1'b0);
   endtask : arm

   // Ends a programming frame, then follows ready/busy on the next select.
   task automatic prog(input logic [1:0] op, input logic [8:0] a,
         input logic [15:0] d, input logic armed);
      int n;
      n = 0;
      cmd(op, a);
      if (op == `EEP_OP_WRITE || (op == `EEP_OP_EXT &&
            a == ext(`EEP_EXT_WRITE_ALL))) begin
         host.send(dw, {16'h0, d});
      end
      host.sel(1'b0);
      chk("oe_deselected", 0, serial_data_out_oe);
      host.sel(1'b1);
      chk("status_oe", armed, serial_data_out_oe);
      if (armed) begin
         chk("status_busy", 0, link_do);
         while (link_do !== 1'b1 && n < WC + 50) begin
            @(negedge clk);
            n++;
         end
         chk("busy_span_ok", 1, n <= WC && n >= WC - 120);
      end
      host.sel(1'b0);
   endtask : prog

   task automatic rd(input logic [8:0] a, input int n,
         input logic [31:0] exp, input string what);
      logic [31:0] v;
      cmd(`EEP_OP_READ, a);
      host.recv(n * dw, v);
      host.sel(1'b0);
      chk(what, exp, v);
   endtask : rd

   // Programming is refused until enabled and again after disable.
   task automatic t_gate;
      prog(`EEP_OP_WRITE, 9'h005, 16'h0F0F, 1'b0);
      arm(`EEP_EXT_ENABLE);
      prog(`EEP_OP_WRITE, 9'h005, 16'hA5C3, 1'b1);
      arm(`EEP_EXT_DISABLE);
      prog(`EEP_OP_WRITE, 9'h005, 16'h1111, 1'b0);
      prog(`EEP_OP_ERASE, 9'h005, 16'h0, 1'b0);
      rd(9'h005, 1, 32'hA5C3, "kept_word");
   endtask : t_gate

   // Overwrite without erase, erase, and a read that wraps the top address.
   task automatic t_stream;
      arm(`EEP_EXT_ENABLE);
      prog(`EEP_OP_WRITE, 9'h0FF, 16'h8001, 1'b1);
      prog(`EEP_OP_WRITE, 9'h000, 16'h1234, 1'b1);
      prog(`EEP_OP_WRITE, 9'h000, 16'h7E5A, 1'b1);
      rd(9'h0FF, 2, 32'h80017E5A, "wrap_read");
      prog(`EEP_OP_ERASE, 9'h000, 16'h0, 1'b1);
      rd(9'h000, 1, 32'h0000FFFF, "erased_word");
   endtask : t_stream

   // Bulk write and bulk erase, with the host running a slow link clock.
   task automatic t_bulk;
      host.half = 16;
      prog(`EEP_OP_EXT, ext(`EEP_EXT_WRITE_ALL), 16'h3C96, 1'b1);
      rd(9'h07F, 2, 32'h3C963C96, "bulk_written");
      prog(`EEP_OP_EXT, ext(`EEP_EXT_ERASE_ALL), 16'h0, 1'b1);
      rd(9'h010, 1, 32'h0000FFFF, "bulk_erased");
      host.half = 8;
   endtask : t_bulk

   // Byte organisation: nine address bits, high byte at odd addresses.
   task automatic t_narrow;
      set_width(1'b0);
      prog(`EEP_OP_WRITE, 9'h021, 16'h005A, 1'b1);
      rd(9'h021, 1, 32'h0000005A, "byte_read");
      rd(9'h1FF, 2, 32'h0000FFFF, "byte_wrap");
      rd(9'h020, 2, 32'h0000FF5A, "byte_pair");
      set_width(1'b1);
      rd(9'h010, 1, 32'h00005AFF, "word_of_bytes");
   endtask : t_narrow

   // Reset, then the scenarios in order.
   initial begin
      rst_b = 1'b0;
      word_width_select = 1'b1;
      repeat (16) @(negedge clk);
      chk("oe_in_reset", 0, serial_data_out_oe);
      rst_b = 1'b1;
      repeat (4) @(negedge clk);
      t_gate();
      t_stream();
      t_bulk();
      t_narrow();
      final_report();
   end

   // Cuts a hang short, well past the expected length of the run.
   initial begin
      repeat (90000) @(posedge clk);
      miscompares++;
      final_report();
   end
endmodule : eep_top_tb
